// *** src/mst_defs.svh ***
// Offsets, field positions, constants and reset values for the tag bypass classifier
`ifndef MST_DEFS_SVH
`define MST_DEFS_SVH

// Header capture depth in bytes
`define MST_HDR_BYTES     32
`define MST_SA_ENTRIES    16

// Byte positions counted from the first DA byte
`define MST_DA_POS        0
`define MST_SA_POS        6
`define MST_ADDR_LEN      6
`define MST_TAG1_POS      12
`define MST_TAG2_POS      16
`define MST_TAG_LEN       4
`define MST_ETYPE_LEN     2
`define MST_LBL1_POS      14
`define MST_LBL2_POS      18
`define MST_LBL_LEN       4
`define MST_SECTAG_LEN    8

// Clear header length ahead of the SecTAG, per mode
`define MST_CLR_STD       12
`define MST_CLR_BYP1      16
`define MST_CLR_BYP2      20
`define MST_CLR_MPLS1     18
`define MST_CLR_MPLS2     22

// Ethertype values
`define MST_TPID_C        16'h8100
`define MST_TPID_S        16'h88A8
`define MST_MPLS_ETYPE    16'h8847
`define MST_SECTAG_ETYPE  16'h88E5

// Classification field bits
`define MST_FLD_DA        0
`define MST_FLD_SA        1
`define MST_FLD_TAG1      2
`define MST_FLD_TAG2      3
`define MST_FLD_ETYPE     4
`define MST_FLD_LBL1      5
`define MST_FLD_LBL2      6
`define MST_FLD_SECTAG    7

// Reset value of each entry's field selection
`define MST_FLD_SEL_RST   8'hFF

// Data FIFO geometry
`define MST_FIFO_WIDTH    9
`define MST_FIFO_DEPTH    8

`endif

// *** src/mst_pkg.sv ***
// Types shared by the tag bypass classifier, its checker and its bench
`default_nettype none
`include "mst_defs.svh"

package mst_pkg;

    typedef enum logic [2:0] {
        MST_MODE_STD   = 3'h0,
        MST_MODE_BYP1  = 3'h1,
        MST_MODE_BYP2  = 3'h2,
        MST_MODE_MPLS1 = 3'h3,
        MST_MODE_MPLS2 = 3'h4
    } mst_mode_type;

    typedef enum logic [1:0] {
        MST_ST_IDLE = 2'h0,
        MST_ST_HDR  = 2'h1,
        MST_ST_BODY = 2'h3
    } mst_fsm_type;

    typedef struct packed {
        logic         key_256;
        logic [7:0]   fld_sel;
        mst_mode_type mode;
    } mst_sa_entry_type;

    typedef struct packed {
        mst_mode_type mode;
        logic         key_256;
        logic [7:0]   fld_vld;
        logic [47:0]  da;
        logic [47:0]  sa;
        logic [15:0]  tpid1;
        logic [11:0]  vid1;
        logic [15:0]  tpid2;
        logic [11:0]  vid2;
        logic [15:0]  etype;
        logic [31:0]  lbl1;
        logic [31:0]  lbl2;
        logic [63:0]  sectag;
        logic [4:0]   sectag_ofs;
        logic         no_sectag;
    } mst_result_type;

    typedef struct packed {
        mst_fsm_type                                fsm;
        logic [5:0]                                 cnt;
        logic [`MST_HDR_BYTES-1:0][7:0]             hdr;
        logic [3:0]                                 sa_idx;
        logic                                       dir_rx;
        mst_sa_entry_type [`MST_SA_ENTRIES-1:0]     tab;
        logic                                       cls_valid;
        mst_result_type                             res;
    } mst_state_type;

endpackage : mst_pkg

`default_nettype wire

// *** src/mst_fifo.sv ***
// Parameterised valid/ready FIFO in the frame data path
`default_nettype none
`include "mst_defs.svh"

module mst_fifo
#(
    parameter int W = `MST_FIFO_WIDTH,
    parameter int D = `MST_FIFO_DEPTH
)
(
    input  wire logic         clk_sys,
    input  wire logic         rst,
    input  wire logic [W-1:0] in_data,
    input  wire logic         in_valid,
    output logic              in_ready,
    output logic      [W-1:0] out_data,
    output logic              out_valid,
    input  wire logic         out_ready
);

    localparam int AW = $clog2(D);

    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0]       wp;
        logic [AW-1:0]       rp;
        logic [AW:0]         cnt;
    } mst_fifo_state_type;

    mst_fifo_state_type st_reg;
    mst_fifo_state_type st_next;
    logic               push;
    logic               pop;

    assign in_ready  = (st_reg.cnt != (AW+1)'(D));
    assign out_valid = (st_reg.cnt != '0);
    assign out_data  = st_reg.mem[st_reg.rp];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always_comb
    begin
        st_next = st_reg;
        if (push)
        begin
            st_next.mem[st_reg.wp] = in_data;
            st_next.wp             = AW'(st_reg.wp + 1'b1);
        end
        if (pop)
        begin
            st_next.rp = AW'(st_reg.rp + 1'b1);
        end
        st_next.cnt = (AW+1)'(st_reg.cnt + (AW+1)'(push) - (AW+1)'(pop));
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            st_reg <= '0;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

endmodule : mst_fifo

`default_nettype wire

// *** src/mst_classifier.sv ***
// Frame header parser and per-entry classification field selector with tag bypass
`default_nettype none
`include "mst_defs.svh"


module mst_classifier
    import mst_pkg::*;
(
    input  wire logic          clk_sys,
    input  wire logic          rst,
    input  wire logic          cfg_wr_en,
    input  wire logic [3:0]    cfg_wr_idx,
    input  wire mst_mode_type  cfg_wr_mode,
    input  wire logic [7:0]    cfg_wr_fld_sel,
    input  wire logic          cfg_wr_key_256,
    input  wire logic          frm_dir_rx,
    input  wire logic [3:0]    frm_sa_idx,
    input  wire logic [7:0]    s_data,
    input  wire logic          s_last,
    input  wire logic          s_valid,
    output logic               s_ready,
    output logic      [7:0]    m_data,
    output logic               m_last,
    output logic               m_valid,
    input  wire logic          m_ready,
    output logic               cls_valid,
    output mst_mode_type       cls_mode,
    output logic               cls_key_256,
    output logic      [7:0]    cls_fld_vld,
    output logic      [47:0]   cls_da,
    output logic      [47:0]   cls_sa,
    output logic      [15:0]   cls_tpid1,
    output logic      [11:0]   cls_vid1,
    output logic      [15:0]   cls_tpid2,
    output logic      [11:0]   cls_vid2,
    output logic      [15:0]   cls_etype,
    output logic      [31:0]   cls_lbl1,
    output logic      [31:0]   cls_lbl2,
    output logic      [63:0]   cls_sectag,
    output logic      [4:0]    cls_sectag_ofs,
    output logic               cls_no_sectag,
    output logic               frm_busy
);

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Helpers

    typedef logic [`MST_HDR_BYTES-1:0][7:0] mst_hdr_type;

    function automatic logic [15:0] get16(input mst_hdr_type hb, input int p);
        return {hb[p], hb[p+1]};
    endfunction : get16

    function automatic logic [31:0] get32(input mst_hdr_type hb, input int p);
        return {hb[p], hb[p+1], hb[p+2], hb[p+3]};
    endfunction : get32

    // Field lies fully inside the bytes seen
    function automatic logic present(input logic [5:0] n, input int p, input int len);
        return int'(n) >= (p + len);
    endfunction : present

    function automatic logic is_vlan(input logic [15:0] t);
        return (t == `MST_TPID_C) || (t == `MST_TPID_S);
    endfunction : is_vlan

    function automatic mst_state_type rst_state();
        mst_state_type s;
        s = '0;
        for (int i = 0; i < `MST_SA_ENTRIES; i++)
        begin
            s.tab[i].fld_sel = `MST_FLD_SEL_RST;
        end
        return s;
    endfunction : rst_state

    localparam mst_state_type ST_RST = rst_state();

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Classification of a captured header

    function automatic mst_result_type classify(
        input mst_hdr_type      hb,
        input logic [5:0]       n,
        input mst_sa_entry_type ent,
        input logic             rx
    );
        mst_result_type r;
        logic [7:0]     av;
        int             clr;
        int             ety_pos;
        logic           tag1;
        logic           tag2;
        logic [15:0]    w1;
        logic [15:0]    w2;
        r       = '0;
        av      = '0;
        clr     = `MST_CLR_STD;
        ety_pos = `MST_TAG1_POS;
        tag1    = is_vlan(get16(hb, `MST_TAG1_POS));
        tag2    = tag1 && is_vlan(get16(hb, `MST_TAG2_POS));
        w1      = get16(hb, `MST_TAG1_POS + 2);
        w2      = get16(hb, `MST_TAG2_POS + 2);
        r.da    = {get16(hb, `MST_DA_POS), get32(hb, `MST_DA_POS + 2)};
        r.sa    = {get16(hb, `MST_SA_POS), get32(hb, `MST_SA_POS + 2)};
        r.tpid1 = get16(hb, `MST_TAG1_POS);
        r.vid1  = w1[11:0];
        r.tpid2 = get16(hb, `MST_TAG2_POS);
        r.vid2  = w2[11:0];
        r.lbl1  = get32(hb, `MST_LBL1_POS);
        r.lbl2  = get32(hb, `MST_LBL2_POS);
        av[`MST_FLD_DA] = present(n, `MST_DA_POS, `MST_ADDR_LEN);
        av[`MST_FLD_SA] = present(n, `MST_SA_POS, `MST_ADDR_LEN);
        // SecTAG position follows SA or the clear headers
        case (ent.mode)
            MST_MODE_STD:   clr = `MST_CLR_STD;
            MST_MODE_BYP1:  clr = `MST_CLR_BYP1;
            MST_MODE_BYP2:  clr = `MST_CLR_BYP2;
            MST_MODE_MPLS1: clr = `MST_CLR_MPLS1;
            MST_MODE_MPLS2: clr = `MST_CLR_MPLS2;
            default:        clr = `MST_CLR_STD;
        endcase
        if (!rx)
        begin
            if ((ent.mode == MST_MODE_MPLS1) || (ent.mode == MST_MODE_MPLS2))
            begin
                r.etype = get16(hb, `MST_TAG1_POS);
                av[`MST_FLD_ETYPE] = present(n, `MST_TAG1_POS, `MST_ETYPE_LEN);
                av[`MST_FLD_LBL1]  = present(n, `MST_LBL1_POS, `MST_LBL_LEN);
                av[`MST_FLD_LBL2]  = (ent.mode == MST_MODE_MPLS2)
                                   && present(n, `MST_LBL2_POS, `MST_LBL_LEN);
            end
            else
            begin
                ety_pos = `MST_TAG1_POS + `MST_TAG_LEN * (int'(tag1) + int'(tag2));
                r.etype = get16(hb, ety_pos);
                av[`MST_FLD_TAG1]  = tag1 && present(n, `MST_TAG1_POS, `MST_TAG_LEN);
                av[`MST_FLD_TAG2]  = tag2 && present(n, `MST_TAG2_POS, `MST_TAG_LEN);
                av[`MST_FLD_ETYPE] = present(n, ety_pos, `MST_ETYPE_LEN);
            end
        end
        else
        begin
            // Only the SecTAG and the clear bytes ahead of it are offered
            r.sectag    = {get32(hb, clr), get32(hb, clr + 4)};
            r.no_sectag = (get16(hb, clr) != `MST_SECTAG_ETYPE);
            av[`MST_FLD_SECTAG] = present(n, clr, `MST_SECTAG_LEN);
            case (ent.mode)
                MST_MODE_STD:
                begin
                    av[`MST_FLD_TAG1] = 1'b0;
                end
                MST_MODE_BYP1:
                begin
                    av[`MST_FLD_TAG1] = present(n, `MST_TAG1_POS, `MST_TAG_LEN);
                end
                MST_MODE_BYP2:
                begin
                    av[`MST_FLD_TAG1] = present(n, `MST_TAG1_POS, `MST_TAG_LEN);
                    av[`MST_FLD_TAG2] = present(n, `MST_TAG2_POS, `MST_TAG_LEN);
                end
                MST_MODE_MPLS1, MST_MODE_MPLS2:
                begin
                    r.etype = get16(hb, `MST_TAG1_POS);
                    av[`MST_FLD_ETYPE] = present(n, `MST_TAG1_POS, `MST_ETYPE_LEN);
                    av[`MST_FLD_LBL1]  = present(n, `MST_LBL1_POS, `MST_LBL_LEN);
                    av[`MST_FLD_LBL2]  = (ent.mode == MST_MODE_MPLS2)
                                       && present(n, `MST_LBL2_POS, `MST_LBL_LEN);
                end
                default:
                begin
                    av[`MST_FLD_TAG1] = 1'b0;
                end
            endcase
        end
        r.fld_vld    = av & ent.fld_sel;
        r.sectag_ofs = 5'(clr);
        r.key_256    = ent.key_256;
        r.mode       = ent.mode;
        return r;
    endfunction : classify

    ////////////////////////////////////////////////////////////////////////////////////////////
    // State

    mst_state_type st_reg;
    mst_state_type st_next;
    logic          acc;
    logic          fin;
    logic [5:0]    fin_n;
    logic [8:0]    fifo_out;

    assign acc = s_valid & s_ready;

    always_comb
    begin
        st_next           = st_reg;
        st_next.cls_valid = 1'b0;
        fin               = 1'b0;
        fin_n             = st_reg.cnt;
        if (cfg_wr_en)
        begin
            st_next.tab[cfg_wr_idx].mode    = cfg_wr_mode;
            st_next.tab[cfg_wr_idx].fld_sel = cfg_wr_fld_sel;
            st_next.tab[cfg_wr_idx].key_256 = cfg_wr_key_256;
        end
        case (st_reg.fsm)
            MST_ST_IDLE:
            begin
                if (acc)
                begin
                    // First byte is the first DA byte
                    st_next.hdr    = '0;
                    st_next.hdr[0] = s_data;
                    st_next.cnt    = 6'h01;
                    st_next.sa_idx = frm_sa_idx;
                    st_next.dir_rx = frm_dir_rx;
                    fin_n          = 6'h01;
                    fin            = s_last;
                    st_next.fsm    = s_last ? MST_ST_IDLE : MST_ST_HDR;
                end
            end
            MST_ST_HDR:
            begin
                if (acc)
                begin
                    st_next.hdr[st_reg.cnt[4:0]] = s_data;
                    st_next.cnt = 6'(st_reg.cnt + 6'h01);
                    fin_n       = 6'(st_reg.cnt + 6'h01);
                    if (s_last)
                    begin
                        fin         = 1'b1;
                        st_next.fsm = MST_ST_IDLE;
                    end
                    else if (st_reg.cnt == 6'(`MST_HDR_BYTES - 1))
                    begin
                        fin         = 1'b1;
                        st_next.fsm = MST_ST_BODY;
                    end
                end
            end
            MST_ST_BODY:
            begin
                if (acc && s_last)
                begin
                    st_next.fsm = MST_ST_IDLE;
                end
            end
            default:
            begin
                st_next.fsm = MST_ST_IDLE;
            end
        endcase
        if (fin)
        begin
            st_next.cls_valid = 1'b1;
            st_next.res = classify(st_next.hdr, fin_n, st_reg.tab[st_next.sa_idx],
                                   st_next.dir_rx);
        end
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            st_reg <= ST_RST;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Data path FIFO; its fullness stalls the source

    mst_fifo #(
        .W (`MST_FIFO_WIDTH),
        .D (`MST_FIFO_DEPTH)
    ) u_fifo (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .in_data   ({s_last, s_data}),
        .in_valid  (s_valid),
        .in_ready  (s_ready),
        .out_data  (fifo_out),
        .out_valid (m_valid),
        .out_ready (m_ready)
    );

    assign m_data = fifo_out[7:0];
    assign m_last = fifo_out[8];

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Result outputs

    assign cls_valid      = st_reg.cls_valid;
    assign cls_mode       = st_reg.res.mode;
    assign cls_key_256    = st_reg.res.key_256;
    assign cls_fld_vld    = st_reg.res.fld_vld;
    assign cls_da         = st_reg.res.da;
    assign cls_sa         = st_reg.res.sa;
    assign cls_tpid1      = st_reg.res.tpid1;
    assign cls_vid1       = st_reg.res.vid1;
    assign cls_tpid2      = st_reg.res.tpid2;
    assign cls_vid2       = st_reg.res.vid2;
    assign cls_etype      = st_reg.res.etype;
    assign cls_lbl1       = st_reg.res.lbl1;
    assign cls_lbl2       = st_reg.res.lbl2;
    assign cls_sectag     = st_reg.res.sectag;
    assign cls_sectag_ofs = st_reg.res.sectag_ofs;
    assign cls_no_sectag  = st_reg.res.no_sectag;
    assign frm_busy       = (st_reg.fsm != MST_ST_IDLE);

endmodule : mst_classifier

`default_nettype wire

// *** verif/mst_classifier_assertions.sv ***
// Checker for the tag bypass classifier ports
`default_nettype none
`include "mst_defs.svh"

module mst_classifier_chk
    import mst_pkg::*;
(
    input wire logic         clk_sys,
    input wire logic         rst,
    input wire logic         s_ready,
    input wire logic [7:0]   m_data,
    input wire logic         m_last,
    input wire logic         m_valid,
    input wire logic         m_ready,
    input wire logic         cls_valid,
    input wire mst_mode_type cls_mode,
    input wire logic [7:0]   cls_fld_vld,
    input wire logic [47:0]  cls_da,
    input wire logic [63:0]  cls_sectag,
    input wire logic [4:0]   cls_sectag_ofs,
    input wire logic         cls_no_sectag
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    sequence s_stall;
        m_valid && !m_ready;
    endsequence
    sequence s_rx_res;
        cls_valid && cls_fld_vld[`MST_FLD_SECTAG];
    endsequence

    property p_pulse;
        cls_valid |=> !cls_valid;
    endproperty
    a_pulse: assert property (p_pulse) else $error("cls_valid longer than one cycle");
    property p_hold;
        !cls_valid |=> cls_valid || ($stable(cls_da) && $stable(cls_fld_vld));
    endproperty
    a_hold: assert property (p_hold) else $error("results changed without pulse");
    property p_ofs;
        cls_valid |-> cls_sectag_ofs == (cls_mode == MST_MODE_STD ? 5'd12 :
            cls_mode == MST_MODE_BYP1 ? 5'd16 : cls_mode == MST_MODE_BYP2 ? 5'd20 :
            cls_mode == MST_MODE_MPLS1 ? 5'd18 : 5'd22);
    endproperty
    a_ofs: assert property (p_ofs) else $error("wrong SecTAG offset");
    property p_tag;
        s_rx_res ##0 !cls_no_sectag |-> cls_sectag[63:48] == `MST_SECTAG_ETYPE;
    endproperty
    a_tag: assert property (p_tag) else $error("SecTAG field without tag type");
    property p_std_rx;
        s_rx_res ##0 cls_mode == MST_MODE_STD |-> cls_fld_vld[6:2] == 5'h0;
    endproperty
    a_std_rx: assert property (p_std_rx) else $error("encrypted field offered");
    property p_byp1;
        s_rx_res ##0 cls_mode == MST_MODE_BYP1 |-> cls_fld_vld[6:3] == 4'h0;
    endproperty
    a_byp1: assert property (p_byp1) else $error("inner tag offered");
    property p_byp2;
        s_rx_res ##0 cls_mode == MST_MODE_BYP2 |-> cls_fld_vld[6:4] == 3'h0;
    endproperty
    a_byp2: assert property (p_byp2) else $error("field past tags offered");
    property p_mpls;
        cls_valid && cls_mode inside {MST_MODE_MPLS1, MST_MODE_MPLS2}
            |-> cls_fld_vld[3:2] == 2'h0 && (cls_mode == MST_MODE_MPLS2 || !cls_fld_vld[6]);
    endproperty
    a_mpls: assert property (p_mpls) else $error("wrong label fields");
    property p_stand;
        s_stall |=> m_valid && $stable(m_data) && $stable(m_last);
    endproperty
    a_stand: assert property (p_stand) else $error("stalled byte changed");
    property p_ready;
        !m_valid |-> s_ready;
    endproperty
    a_ready: assert property (p_ready) else $error("empty buffer refuses");
endmodule : mst_classifier_chk

bind mst_classifier mst_classifier_chk i_mst_classifier_chk (.clk_sys(clk_sys), .rst(rst),
    .s_ready(s_ready), .m_data(m_data), .m_last(m_last), .m_valid(m_valid),
    .m_ready(m_ready), .cls_valid(cls_valid), .cls_mode(cls_mode),
    .cls_fld_vld(cls_fld_vld), .cls_da(cls_da), .cls_sectag(cls_sectag),
    .cls_sectag_ofs(cls_sectag_ofs), .cls_no_sectag(cls_no_sectag));

`default_nettype wire

// *** verif/mst_mac_sink.sv ***
// Line-side MAC model taking bytes from the classifier
`default_nettype none

module mst_mac_sink
(
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic       slow,
    input  wire logic [7:0] m_data,
    input  wire logic       m_last,
    input  wire logic       m_valid,
    output var logic        m_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [8:0] got [$];
    logic [1:0] cyc;
    initial m_ready = 1'b0;
    initial cyc = 2'h0;
    // Slow mode takes one byte in four cycles
    always @(negedge clk_sys)
    begin
        cyc = cyc + 2'h1;
        m_ready = !rst && (!slow || cyc == 2'h0);
    end
    always @(posedge clk_sys)
        if (m_valid && m_ready)
            got.push_back({m_last, m_data});
endmodule : mst_mac_sink

`default_nettype wire

// *** verif/tb_top.sv ***
// Self-checking bench for the tag bypass classifier
`default_nettype none

module tb_top
    import mst_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic cfg_wr_en = 1'b0, cfg_wr_key_256 = 1'b0, frm_dir_rx = 1'b0;
    logic [3:0] cfg_wr_idx = 4'h0, frm_sa_idx = 4'h0;
    mst_mode_type cfg_wr_mode = MST_MODE_STD;
    logic [7:0] cfg_wr_fld_sel = 8'h00, s_data = 8'h00, m_data, cls_fld_vld;
    logic s_last = 1'b0, s_valid = 1'b0, slow = 1'b0;
    logic s_ready, m_last, m_valid, m_ready, cls_valid, cls_key_256, cls_no_sectag, frm_busy;
    mst_mode_type cls_mode;
    logic [47:0] cls_da, cls_sa;
    logic [15:0] cls_tpid1, cls_tpid2, cls_etype;
    logic [11:0] cls_vid1, cls_vid2;
    logic [31:0] cls_lbl1, cls_lbl2;
    logic [63:0] cls_sectag;
    logic [4:0] cls_sectag_ofs;
    int failures = 0, n_tests = 0, n_cls = 0, cyc = 0, full_seen = 0;
    logic [7:0] frm [$];

    mst_classifier i_mst_classifier (.clk_sys(clk_sys), .rst(rst), .cfg_wr_en(cfg_wr_en),
        .cfg_wr_idx(cfg_wr_idx), .cfg_wr_mode(cfg_wr_mode), .cfg_wr_fld_sel(cfg_wr_fld_sel),
        .cfg_wr_key_256(cfg_wr_key_256), .frm_dir_rx(frm_dir_rx), .frm_sa_idx(frm_sa_idx),
        .s_data(s_data), .s_last(s_last), .s_valid(s_valid), .s_ready(s_ready),
        .m_data(m_data), .m_last(m_last), .m_valid(m_valid), .m_ready(m_ready),
        .cls_valid(cls_valid), .cls_mode(cls_mode), .cls_key_256(cls_key_256),
        .cls_fld_vld(cls_fld_vld), .cls_da(cls_da), .cls_sa(cls_sa), .cls_tpid1(cls_tpid1),
        .cls_vid1(cls_vid1), .cls_tpid2(cls_tpid2), .cls_vid2(cls_vid2),
        .cls_etype(cls_etype), .cls_lbl1(cls_lbl1), .cls_lbl2(cls_lbl2),
        .cls_sectag(cls_sectag), .cls_sectag_ofs(cls_sectag_ofs),
        .cls_no_sectag(cls_no_sectag), .frm_busy(frm_busy));
    mst_mac_sink i_mst_mac_sink (.clk_sys(clk_sys), .rst(rst), .slow(slow), .m_data(m_data),
        .m_last(m_last), .m_valid(m_valid), .m_ready(m_ready));

    initial forever #12.5 clk_sys = ~clk_sys;
    always @(posedge clk_sys)
    begin
        cyc <= cyc + 1;
        if (cls_valid === 1'b1)
            n_cls <= n_cls + 1;
        if (s_valid && s_ready !== 1'b1)
            full_seen <= full_seen + 1;
        if (cyc == 20000)
        begin
            failures++;
            test_done();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic test_done();
        if (failures == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : test_done
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            failures++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic cfg(input logic [3:0] idx, input mst_mode_type md, input logic [7:0] sel,
                       input logic key);
        @(negedge clk_sys);
        cfg_wr_en = 1'b1;
        cfg_wr_idx = idx;
        cfg_wr_mode = md;
        cfg_wr_fld_sel = sel;
        cfg_wr_key_256 = key;
        @(negedge clk_sys);
        cfg_wr_en = 1'b0;
    endtask : cfg
    task automatic p16(input logic [15:0] v);
        frm.push_back(v[15:8]);
        frm.push_back(v[7:0]);
    endtask : p16
    task automatic p32(input logic [31:0] v);
        p16(v[31:16]);
        p16(v[15:0]);
    endtask : p32
    // Addresses first, no preamble or FCS
    task automatic hdr();
        frm.delete();
        p16(16'h0201);
        p32(32'h0203_0405);
        p16(16'h0A0B);
        p32(32'h0C0D_0E0F);
    endtask : hdr
    task automatic sectag_pad();
        p32(32'h88E5_2C01);
        p32(32'h0000_0007);
        while (frm.size() < 40)
            frm.push_back(8'h5A);
    endtask : sectag_pad
    task automatic send(input logic dir, input logic [3:0] idx, input logic [7:0] fld);
        int n0;
        n0 = n_cls;
        for (int k = 0; k < frm.size(); k++)
        begin
            @(negedge clk_sys);
            if (k == 1)
                chk(frm_busy, 1'b1);
            s_valid = 1'b1;
            s_data = frm[k];
            s_last = (k == frm.size() - 1);
            frm_dir_rx = dir;
            frm_sa_idx = idx;
            while (s_ready !== 1'b1)
                @(negedge clk_sys);
        end
        @(negedge clk_sys);
        s_valid = 1'b0;
        s_last = 1'b0;
        while (i_mst_mac_sink.got.size() < frm.size())
            @(negedge clk_sys);
        for (int k = 0; k < frm.size(); k++)
            chk(i_mst_mac_sink.got[k], {k == frm.size() - 1, frm[k]});
        i_mst_mac_sink.got.delete();
        chk(frm_busy, 1'b0);
        chk(n_cls, n0 + 1);
        chk(cls_da, 48'h0201_0203_0405);
        chk(cls_sa, 48'h0A0B_0C0D_0E0F);
        chk(cls_fld_vld, fld);
    endtask : send

    ////////////////////////////////////////////////////////////////////////
    task automatic t_std();
        hdr();
        sectag_pad();
        send(1'b1, 4'h7, 8'h83);
        chk(cls_sectag, 64'h88E5_2C01_0000_0007);
        chk({cls_mode, cls_key_256, cls_no_sectag, cls_sectag_ofs}, {3'h0, 2'h0, 5'd12});
        cfg(4'h3, MST_MODE_STD, 8'hFF, 1'b1);
        hdr();
        p32(32'h8100_0123);
        p32(32'h88A8_0456);
        p16(16'h0800);
        sectag_pad();
        send(1'b0, 4'h3, 8'h1F);
        chk({cls_tpid1, cls_vid1, cls_tpid2, cls_vid2}, {16'h8100, 12'h123, 16'h88A8, 12'h456});
        chk({cls_etype, cls_key_256, cls_sectag_ofs}, {16'h0800, 1'b1, 5'd12});
    endtask : t_std
    task automatic t_byp();
        slow = 1'b1;
        for (int m = 1; m <= 2; m++)
        begin
            cfg(4'h2, mst_mode_type'(m), 8'hFF, 1'b0);
            hdr();
            p32(32'h8100_0123);
            if (m == 2)
                p32(32'h8100_0456);
            sectag_pad();
            send(1'b1, 4'h2, m == 1 ? 8'h87 : 8'h8F);
            chk({cls_tpid1, cls_vid1, cls_sectag_ofs}, {16'h8100, 12'h123, 5'(12 + 4 * m)});
            chk(cls_sectag, 64'h88E5_2C01_0000_0007);
        end
        slow = 1'b0;
        chk(full_seen > 0, 1'b1);
    endtask : t_byp
    task automatic t_mpls();
        for (int m = 3; m <= 4; m++)
        begin
            cfg(4'hF, mst_mode_type'(m), 8'hFF, 1'b1);
            hdr();
            p16(16'h8847);
            p32(32'h0001_2140);
            if (m == 4)
                p32(32'h0003_4141);
            sectag_pad();
            send(1'b1, 4'hF, m == 3 ? 8'hB3 : 8'hF3);
            chk({cls_etype, cls_lbl1, cls_sectag_ofs}, {16'h8847, 32'h0001_2140, 5'(6 + 4 * m)});
            if (m == 4)
                chk(cls_lbl2, 32'h0003_4141);
        end
    endtask : t_mpls
    task automatic t_sel();
        cfg(4'h5, MST_MODE_STD, 8'h81, 1'b0);
        hdr();
        p16(16'h0800);
        sectag_pad();
        send(1'b1, 4'h5, 8'h81);
        chk(cls_no_sectag, 1'b1);
    endtask : t_sel

    initial
    begin
        repeat (8) @(negedge clk_sys);
        chk({s_ready, m_valid, cls_valid, frm_busy, cls_fld_vld}, {4'b1000, 8'h00});
        rst = 1'b0;
        t_std();
        t_byp();
        t_mpls();
        t_sel();
        test_done();
    end
endmodule : tb_top

`default_nettype wire
